//--- logic/gp_pkg.sv
// Purpose: Constants and types shared by the gpio port block
// Assumes: 32-bit register port, eight pins to a port
// Notes: Register index = port * 8 + register select
package gp_pkg;

    // ========================================
    // Widths
    localparam int GP_DATA_W = 32;
    localparam int GP_PORT_W = 8;
    localparam int GP_PORTS_MAX = 8;
    localparam int GP_REG_SEL_W = 3;
    localparam int GP_PORT_SEL_W = 3;
    localparam int GP_ADDR_W = GP_REG_SEL_W + GP_PORT_SEL_W;
    localparam int GP_MODE_W = 3;
    localparam int GP_SEL_W = 2;

    // ========================================
    // Register selects within a port
    localparam logic [2:0] GP_REG_OUT = 3'h0;
    localparam logic [2:0] GP_REG_PIN = 3'h1;
    localparam logic [2:0] GP_REG_MODE = 3'h2;
    localparam logic [2:0] GP_REG_CFG = 3'h3;
    localparam logic [2:0] GP_REG_MUX = 3'h4;
    localparam logic [2:0] GP_REG_IRQ_EN = 3'h5;
    localparam logic [2:0] GP_REG_IRQ_PEND = 3'h6;

    // ========================================
    // Field positions
    localparam int GP_CFG_IN_EN_LSB = 0;
    localparam int GP_CFG_OUT_EN_LSB = 8;
    localparam int GP_CFG_LVTTL_LSB = 16;
    localparam int GP_CFG_SLOW_LSB = 24;
    localparam int GP_IRQ_RISE_LSB = 0;
    localparam int GP_IRQ_FALL_LSB = 8;

    // ========================================
    // Reset values and present-pin mask
    localparam logic [7:0] GP_OUT_RST = 8'h00;
    localparam logic [23:0] GP_MODE_RST = 24'h000000;
    localparam logic [31:0] GP_CFG_RST = 32'h00000000;
    localparam logic [15:0] GP_MUX_RST = 16'h0000;
    localparam logic [15:0] GP_IRQ_EN_RST = 16'h0000;
    localparam logic [39:0] GP_PIN_PRESENT = 40'h0fffffffff;

    // ========================================
    // Drive modes and output sources
    typedef enum logic [2:0] {
        GP_DM_ANALOG,
        GP_DM_INPUT,
        GP_DM_WEAK_UP,
        GP_DM_WEAK_DN,
        GP_DM_OD_LO,
        GP_DM_OD_HI,
        GP_DM_STRONG,
        GP_DM_WEAK_BOTH
    } gp_mode_e;

    localparam logic [1:0] GP_SEL_REG = 2'h0;
    localparam logic [1:0] GP_SEL_A = 2'h1;
    localparam logic [1:0] GP_SEL_B = 2'h2;
    localparam logic [1:0] GP_SEL_C = 2'h3;

endpackage

//--- logic/gp_port_block.sv
// Purpose: Ports of gpio pins with modes, muxing and pin events
// Assumes: Pins arrive asynchronous, register port on sys_clk
// Notes: All pad controls and request lines come from flops
//
// Contract
// - Eight drive modes per pin
// - Analog mode disables input and output buffers
// - Per-pin CMOS or LVTTL threshold select
// - Independent per-pin input and output enables
// - Selectable slow output slew per pin
// - Ports up to eight pins, some narrower
// - Reset disables every pin buffer
// - Per-pin mux of peripherals or port register
// - Port output register holds driven values
// - Pin-state register returns sampled pin levels
// - Pin events only when interrupt enabled
// - One request per port, five ports
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps

module gp_port_block
    import gp_pkg::*;
#(
    parameter int NUM_PORTS = 5,
    parameter logic [39:0] PIN_PRESENT = GP_PIN_PRESENT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [GP_ADDR_W-1:0] reg_addr,
    input wire logic [GP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [GP_DATA_W-1:0] reg_rdata,
    // Peripheral sources and sampled pins
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] periph_a_out,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] periph_b_out,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] periph_c_out,
    output logic [NUM_PORTS*GP_PORT_W-1:0] periph_in,
    // Pads
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_in,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_out,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_oe,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_pull_up,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_pull_dn,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_in_en,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_lvttl,
    output logic [NUM_PORTS*GP_PORT_W-1:0] pad_slow,
    // Port requests
    output logic [NUM_PORTS-1:0] irq
);

    localparam int NPIN = NUM_PORTS * GP_PORT_W;

    // ========================================
    // Elaboration check
    if (NUM_PORTS < 1 || NUM_PORTS > GP_PORTS_MAX) begin : g_chk
        $error("gp_port_block: NUM_PORTS out of range");
    end
    if (NUM_PORTS * GP_PORT_W > $bits(PIN_PRESENT)) begin : g_chk_pins
        $error("gp_port_block: PIN_PRESENT has fewer bits than pins");
    end
    if (GP_PORT_W * GP_MODE_W > 24) begin : g_chk_mode
        $error("gp_port_block: mode fields overflow their register");
    end
    if (GP_PORT_W * GP_SEL_W > 16) begin : g_chk_mux
        $error("gp_port_block: mux fields overflow their register");
    end

    // ========================================
    // Helpers
    // Returns {oe, out, pull_up, pull_dn}
    function automatic logic [3:0] gp_drive(logic [2:0] mode, logic v);
        logic [3:0] r;
        r = 4'h0;
        case (gp_mode_e'(mode))
            GP_DM_WEAK_UP: r = v ? 4'b0010 : 4'b1000;
            GP_DM_WEAK_DN: r = v ? 4'b1100 : 4'b0001;
            GP_DM_OD_LO: r = v ? 4'b0000 : 4'b1000;
            GP_DM_OD_HI: r = v ? 4'b1100 : 4'b0000;
            GP_DM_STRONG: r = {1'b1, v, 2'b00};
            GP_DM_WEAK_BOTH: r = v ? 4'b0010 : 4'b0001;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic gp_port_ok(logic [GP_ADDR_W-1:0] a);
        return 32'(a[GP_ADDR_W-1:GP_REG_SEL_W]) < NUM_PORTS;
    endfunction

    // ========================================
    // Decode
    logic [GP_PORT_SEL_W-1:0] port_sel;
    logic [GP_REG_SEL_W-1:0] reg_sel;
    logic acc_ok;
    logic wr_hit;
    logic rd_hit;
    logic pend_wr;

    assign port_sel = reg_addr[GP_ADDR_W-1:GP_REG_SEL_W];
    assign reg_sel = reg_addr[GP_REG_SEL_W-1:0];
    assign acc_ok = gp_port_ok(reg_addr);
    assign wr_hit = reg_wr && acc_ok;
    assign rd_hit = reg_rd && acc_ok;
    assign pend_wr = wr_hit && reg_sel == GP_REG_IRQ_PEND;

    // ========================================
    // Register storage
    logic [7:0] out_q [NUM_PORTS];
    logic [23:0] mode_q [NUM_PORTS];
    logic [31:0] cfg_q [NUM_PORTS];
    logic [15:0] mux_q [NUM_PORTS];
    logic [15:0] irq_en_q [NUM_PORTS];
    logic [7:0] pend_q [NUM_PORTS];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                out_q[p] <= GP_OUT_RST;
                mode_q[p] <= GP_MODE_RST;
                cfg_q[p] <= GP_CFG_RST;
                mux_q[p] <= GP_MUX_RST;
                irq_en_q[p] <= GP_IRQ_EN_RST;
            end
        end else if (wr_hit) begin
            case (reg_sel)
                GP_REG_OUT: begin
                    out_q[port_sel] <= reg_wdata[7:0];
                end
                GP_REG_MODE: begin
                    mode_q[port_sel] <= reg_wdata[23:0];
                end
                GP_REG_CFG: begin
                    cfg_q[port_sel] <= reg_wdata;
                end
                GP_REG_MUX: begin
                    mux_q[port_sel] <= reg_wdata[15:0];
                end
                GP_REG_IRQ_EN: begin
                    irq_en_q[port_sel] <= reg_wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Per-pin view
    logic [NPIN-1:0] out_en_w;
    logic [NPIN-1:0] in_en_w;
    logic [NPIN-1:0] lvttl_w;
    logic [NPIN-1:0] slow_w;
    logic [NPIN-1:0] drv_v;
    logic [NPIN-1:0] rise_en;
    logic [NPIN-1:0] fall_en;
    logic [3:0] drv_w [NPIN];

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam int P = i / GP_PORT_W;
        localparam int B = i % GP_PORT_W;
        logic [2:0] md;
        logic [1:0] sel;
        assign md = mode_q[P][B*GP_MODE_W +: GP_MODE_W];
        assign sel = mux_q[P][B*GP_SEL_W +: GP_SEL_W];
        assign out_en_w[i] = cfg_q[P][GP_CFG_OUT_EN_LSB+B];
        assign in_en_w[i] = cfg_q[P][GP_CFG_IN_EN_LSB+B]
            && gp_mode_e'(md) != GP_DM_ANALOG
            && PIN_PRESENT[i];
        assign lvttl_w[i] = cfg_q[P][GP_CFG_LVTTL_LSB+B];
        assign slow_w[i] = cfg_q[P][GP_CFG_SLOW_LSB+B];
        assign rise_en[i] = irq_en_q[P][GP_IRQ_RISE_LSB+B];
        assign fall_en[i] = irq_en_q[P][GP_IRQ_FALL_LSB+B];
        always_comb begin
            case (sel)
                GP_SEL_A: drv_v[i] = periph_a_out[i];
                GP_SEL_B: drv_v[i] = periph_b_out[i];
                GP_SEL_C: drv_v[i] = periph_c_out[i];
                default: drv_v[i] = out_q[P][B];
            endcase
        end
        assign drv_w[i] = gp_drive(md, drv_v[i]);
    end

    // ========================================
    // Pad controls
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pull_up <= '0;
            pad_pull_dn <= '0;
            pad_in_en <= '0;
            pad_lvttl <= '0;
            pad_slow <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                pad_out[i] <= drv_w[i][2] && PIN_PRESENT[i];
                pad_oe[i] <= drv_w[i][3] && out_en_w[i]
                    && PIN_PRESENT[i];
                pad_pull_up[i] <= drv_w[i][1] && out_en_w[i]
                    && PIN_PRESENT[i];
                pad_pull_dn[i] <= drv_w[i][0] && out_en_w[i]
                    && PIN_PRESENT[i];
                pad_in_en[i] <= in_en_w[i];
                pad_lvttl[i] <= lvttl_w[i] && PIN_PRESENT[i];
                pad_slow[i] <= slow_w[i] && PIN_PRESENT[i];
            end
        end
    end

    // ========================================
    // Pin sampling
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic [NPIN-1:0] state_q;
    logic [NPIN-1:0] state_w;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pad_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign state_w = pin_s2_q & in_en_w;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= '0;
            periph_in <= '0;
        end else begin
            state_q <= state_w;
            periph_in <= state_w;
        end
    end

    // ========================================
    // Pin events
    logic [NPIN-1:0] evt_w;

    assign evt_w = ((state_w & ~state_q & rise_en)
        | (~state_w & state_q & fall_en)) & PIN_PRESENT[NPIN-1:0];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                pend_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (pend_wr && 32'(port_sel) == p) begin
                    pend_q[p] <= (pend_q[p] & ~reg_wdata[7:0])
                        | evt_w[p*GP_PORT_W +: GP_PORT_W];
                end else begin
                    pend_q[p] <= pend_q[p]
                        | evt_w[p*GP_PORT_W +: GP_PORT_W];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                irq[p] <= |pend_q[p];
            end
        end
    end

    // ========================================
    // Read port
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (rd_hit) begin
            case (reg_sel)
                GP_REG_OUT: reg_rdata <= {24'h000000, out_q[port_sel]};
                GP_REG_PIN: begin
                    reg_rdata <= {24'h000000,
                        state_q[port_sel*GP_PORT_W +: GP_PORT_W]};
                end
                GP_REG_MODE: reg_rdata <= {8'h00, mode_q[port_sel]};
                GP_REG_CFG: reg_rdata <= cfg_q[port_sel];
                GP_REG_MUX: reg_rdata <= {16'h0000, mux_q[port_sel]};
                GP_REG_IRQ_EN: reg_rdata <= {16'h0000, irq_en_q[port_sel]};
                GP_REG_IRQ_PEND: reg_rdata <= {24'h000000, pend_q[port_sel]};
                default: reg_rdata <= '0;
            endcase
        end else if (reg_rd) begin
            reg_rdata <= '0;
        end
    end

endmodule

//--- dv/gp_port_block_checker.sv
// Purpose: Port-level assertions for the gpio port block
// Assumes: Five ports, config effects watched on port 0
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module gp_port_block_checker
    import gp_pkg::*;
#(
    parameter int NUM_PORTS = 5
) (
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [GP_ADDR_W-1:0] reg_addr,
    input wire logic [GP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [GP_DATA_W-1:0] reg_rdata,
    // Pads and requests
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_in,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] periph_in,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_oe,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_pull_up,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_pull_dn,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_in_en,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_lvttl,
    input wire logic [NUM_PORTS*GP_PORT_W-1:0] pad_slow,
    input wire logic [NUM_PORTS-1:0] irq
);
    // ========
    // Decodes
    logic p0, hole, cfg0;
    logic [7:0] drv0;
    assign p0 = reg_addr[5:3] == 3'h0;
    assign hole = reg_addr[5:3] >= NUM_PORTS || reg_addr[2:0] == 3'h7;
    assign cfg0 = reg_wr && p0 && reg_addr[2:0] == GP_REG_CFG;
    assign drv0 = pad_oe[7:0] | pad_pull_up[7:0] | pad_pull_dn[7:0];
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ========
    // Assertions
    AST_RST_OFF: assert property ($fell(reset) |->
        (pad_oe | pad_in_en | pad_pull_up) == '0 && irq == '0)
        else $error("pad or request active after reset");
    AST_ANALOG: assert property (reg_wr && p0 &&
        reg_addr[2:0] == GP_REG_MODE && reg_wdata[23:0] == 24'h0
        |=> ##1 (drv0 | pad_in_en[7:0]) == 8'h00)
        else $error("analog mode left a buffer on");
    AST_OUT_EN: assert property (cfg0 && reg_wdata[15:8] == 8'h00
        |=> ##1 drv0 == 8'h00) else $error("drive with output disabled");
    AST_LVTTL: assert property (cfg0 |=> ##1
        pad_lvttl[7:0] == $past(reg_wdata[23:16], 2))
        else $error("threshold select wrong");
    AST_SLOW: assert property (cfg0 |=> ##1
        pad_slow[7:0] == $past(reg_wdata[31:24], 2))
        else $error("slew select wrong");
    AST_HOLE: assert property (reg_rd && hole |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    AST_IRQ_OR: assert property (reg_rd && p0 &&
        reg_addr[2:0] == GP_REG_IRQ_PEND |=> (|reg_rdata[7:0]) == irq[0])
        else $error("request differs from pending flags");
    AST_PIN: assert property (
        (pad_in_en[0] && $stable(pad_in[0]))[*4]
        |-> periph_in[0] == pad_in[0]) else $error("pin level not seen");
    COV_IRQ: cover property ($rose(irq[0]));
    COV_CLR: cover property ($fell(irq[0]));
    COV_HOLE: cover property (reg_rd && hole);
endmodule

//--- dv/gp_pad_model.sv
// Purpose: Pins and outside circuit seen by the gpio port block
// Assumes: Outside drivers win over the block
// Notes: Undriven pins without pulls toggle every cycle
`timescale 1ns/1ps
module gp_pad_model (
    // Clock
    input wire logic sys_clk,
    // Block pad controls
    input wire logic [39:0] pad_out,
    input wire logic [39:0] pad_oe,
    input wire logic [39:0] pad_pull_up,
    input wire logic [39:0] pad_pull_dn,
    // Outside drivers
    input wire logic [39:0] ext_en,
    input wire logic [39:0] ext_val,
    // Pin levels
    output logic [39:0] pad_in
);
    logic [39:0] float_q = 40'h5555555555;
    always @(posedge sys_clk) begin
        float_q <= ~float_q;
    end
    assign pad_in = (ext_en & ext_val) | (~ext_en & pad_oe & pad_out) |
        (~ext_en & ~pad_oe & (pad_pull_up | (~pad_pull_dn & float_q)));
endmodule

//--- dv/gp_port_block_tb_top.sv
// Purpose: Self-checking bench for the gpio port block
// Assumes: Default five ports, scenarios on port 0 plus config checks on ports 4 and 5
// Notes: Pads loop back through the pin model
`timescale 1ns/1ps
module gp_port_block_tb_top;
    import gp_pkg::*;
    logic sys_clk, reset, reg_wr, reg_rd;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [39:0] pa, pb, pc, periph_in, pad_in, pad_out, pad_oe, pu, pd;
    logic [39:0] pad_in_en, pad_lvttl, pad_slow, ext_en, ext_val;
    logic [4:0] irq;
    logic [7:0] o, oe, up, dn, drv;
    logic [7:0] src [4];
    int fail_count, checked;

    gp_port_block i_gp_port_block (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_a_out(pa),
        .periph_b_out(pb), .periph_c_out(pc), .periph_in(periph_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pu), .pad_pull_dn(pd), .pad_in_en(pad_in_en),
        .pad_lvttl(pad_lvttl), .pad_slow(pad_slow), .irq(irq));
    gp_pad_model i_gp_pad_model (.sys_clk(sys_clk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pull_up(pu), .pad_pull_dn(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // ========
    // Bus and compare tasks
    task automatic wr(input logic [2:0] p, s, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= {p, s};
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] p, s, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= {p, s};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        checked++;
        if (reg_rdata !== e) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, reg_rdata, e);
        end
    endtask
    task automatic chk_pad(input logic [39:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ========
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100us;
        fail_count++;
        tally_and_finish;
    end

    // ========
    // Scenarios
    initial begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 40'h0};
        {pa, pb, pc} = {40'h3c, 40'h96, 40'h0f};
        {ext_en, ext_val, fail_count, checked} = '0;
        o = 8'ha5;
        src = '{o, 8'h3c, 8'h96, 8'h0f};
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk_pad(pad_oe | pad_in_en | pu | pd | irq, '0);
        for (int s = 0; s < 8; s++) rchk(3'h0, s[2:0], '0);
        wr(3'h5, GP_REG_CFG, '1);
        wait_cyc(2);
        chk_pad(pad_lvttl | pad_slow, '0);
        rchk(3'h5, GP_REG_CFG, '0);
        wr(3'h4, GP_REG_CFG, '1);
        wait_cyc(2);
        chk_pad({pad_lvttl[39:32], pad_slow[39:32]}, 16'h0f0f);
        wr(3'h0, GP_REG_OUT, {24'h0, o});
        wr(3'h0, GP_REG_CFG, 32'h3cc3ffff);
        for (int m = 0; m < 8; m++) begin
            wr(3'h0, GP_REG_MODE, {8{m[2:0]}});
            wait_cyc(4);
            oe = m == 6 ? 8'hff : m == 3 || m == 5 ? o :
                m == 2 || m == 4 ? ~o : 8'h00;
            up = m == 2 || m == 7 ? o : 8'h00;
            dn = m == 3 || m == 7 ? ~o : 8'h00;
            drv = m == 6 ? o : m == 3 || m == 5 ? 8'hff : 8'h00;
            chk_pad({pad_oe[7:0], pu[7:0], pd[7:0], pad_in_en[7:0],
                pad_out[7:0] & oe}, {oe, up, dn, m ? 8'hff : 8'h0, drv & oe});
            if (m inside {2, 3, 6, 7}) rchk(3'h0, GP_REG_PIN, o);
        end
        chk_pad({pad_slow[7:0], pad_lvttl[7:0]}, 40'h3cc3);
        wr(3'h0, GP_REG_CFG, 32'h000000ff);
        wait_cyc(2);
        chk_pad({pad_oe[7:0], pu[7:0], pd[7:0],
            pad_in_en[7:0]}, 40'hff);
        wr(3'h0, GP_REG_CFG, 32'h0000ff00);
        wait_cyc(4);
        chk_pad({pu[7:0], pd[7:0], pad_in_en[7:0]}, {o, ~o, 8'h0});
        rchk(3'h0, GP_REG_PIN, '0);
        wr(3'h0, GP_REG_MODE, {8{3'h6}});
        for (int s = 0; s < 4; s++) begin
            wr(3'h0, GP_REG_MUX, {8{s[1:0]}});
            wait_cyc(2);
            chk_pad(pad_out[7:0], src[s]);
        end
        ext_en <= 40'h1;
        wr(3'h0, GP_REG_MUX, '0);
        wr(3'h0, GP_REG_MODE, 32'h1);
        wr(3'h0, GP_REG_CFG, 32'h1);
        wait_cyc(6);
        ext_val <= 40'h1;
        wait_cyc(6);
        chk_pad(irq, '0);
        rchk(3'h0, GP_REG_IRQ_PEND, '0);
        ext_val <= 40'h0;
        wr(3'h0, GP_REG_IRQ_EN, 32'h1);
        wait_cyc(6);
        ext_val <= 40'h1;
        wait_cyc(6);
        chk_pad(irq, 40'h1);
        chk_pad(periph_in, 40'h1);
        rchk(3'h0, GP_REG_IRQ_PEND, 32'h1);
        rchk(3'h0, GP_REG_PIN, 32'h1);
        wr(3'h0, GP_REG_IRQ_PEND, 32'h1);
        wait_cyc(3);
        chk_pad(irq, '0);
        wr(3'h0, GP_REG_IRQ_EN, 32'h100);
        ext_val <= 40'h0;
        wait_cyc(6);
        chk_pad(irq, 40'h1);
        tally_and_finish;
    end
endmodule

bind gp_port_block gp_port_block_checker #(.NUM_PORTS(NUM_PORTS))
    i_gp_port_block_checker (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .periph_in(periph_in), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_dn(pad_pull_dn), .pad_in_en(pad_in_en),
    .pad_lvttl(pad_lvttl), .pad_slow(pad_slow), .irq(irq));
